/* rtl/alarm_mgr_defs.svh */
// constants for the converter alarm manager
`ifndef ALARM_MGR_DEFS_SVH
`define ALARM_MGR_DEFS_SVH
// ****************************************
// display codes (upper byte major, lower byte minor)
// ****************************************
`define CODE_NONE      16'h0000
`define CODE_UNDERVOLT 16'h0a10
`define CODE_RAM       16'h0a12
`define CODE_NVMEM     16'h0a15
`define CODE_BOARD     16'h0a17
`define CODE_FLASH     16'h0a19
`define CODE_REGEN     16'h0a30
`define CODE_OVERVOLT  16'h0a33
`define CODE_PARAM     16'h0a37
`define CODE_MCDRIVE   16'h0a38
`define CODE_OPENPH    16'h0a39
`define CODE_INRUSH    16'h0a3a
`define CODE_OVERHEAT  16'h0a45
`define CODE_FAN       16'h0a47
`define CODE_OVLD1     16'h0a50
`define CODE_OVLD2     16'h0a51
`define CODE_WDOG      16'h0888
`define CODE_W_HEAT    16'h0a91
`define CODE_W_REGEN   16'h0ae0
`define CODE_W_OVLD    16'h0ae1
`define CODE_W_STOP    16'h0ae6
`define CODE_W_FAN     16'h0ae8
// ****************************************
// bit positions of the alarm vector
// ****************************************
`define ALM_UNDERVOLT 0
`define ALM_RAM       1
`define ALM_NVMEM     2
`define ALM_BOARD     3
`define ALM_FLASH     4
`define ALM_REGEN     5
`define ALM_OVERVOLT  6
`define ALM_PARAM     7
`define ALM_MCDRIVE   8
`define ALM_OPENPH    9
`define ALM_INRUSH    10
`define ALM_OVERHEAT  11
`define ALM_FAN       12
`define ALM_OVLD1     13
`define ALM_OVLD2     14
`define ALM_WDOG      15
// reset-clearable subset: undervolt, overvolt, regen, overheat, overload 1/2
`define ALM_CLEARABLE 16'h6861
// ****************************************
// timing and limits
// ****************************************
`define CLK_FREQ_HZ     25000000
`define PWR_LOSS_MS     60
`define PWR_LOSS_CYCLES ((`CLK_FREQ_HZ / 1000) * `PWR_LOSS_MS + 1)
`define NV_WRITE_LIMIT  100000
`endif

/* rtl/alarm_mgr_pkg.sv */
// types for the converter alarm manager
`default_nettype none
package alarm_mgr_pkg;
  // fault inputs grouped by kind
  typedef struct packed {
    logic [15:0] alarms;  // one per alarm position
    logic [4:0]  warns;   // heat, regen load, overload, forced stop, fan
  } fault_in_t;
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_WARN  = 3'b010,
    ST_ALARM = 3'b100
  } mgr_state_t;
endpackage
`default_nettype wire

/* rtl/alarm_mgr.sv */
// converter alarm manager: latches faults, shows codes, drives trouble output
// Summary of operation
// - a detected fault puts its code on the display; alarms go before warnings, and the lowest bit wins.
// - power-on reset clears every latched alarm, clearable or not.
// - only undervolt, overvolt, regen, overheat, overload 1 and 2 clear on the clear input or panel key.
// - entering the alarm state turns the trouble output to its off level.
// - while an alarm is latched the display shows that alarm's own code.
// - control supply loss longer than 60 ms raises the undervoltage alarm.
// - more than 100,000 nonvolatile writes raises the nonvolatile memory alarm.
// - warnings use their own codes, distinct from alarms.
// - board and cpu part faults raise their own alarm, cleared only by power cycle.
`include "alarm_mgr_defs.svh"
`default_nettype none
module alarm_mgr
  import alarm_mgr_pkg::*;
#(
  parameter int unsigned PWR_LOSS_CYCLES = `PWR_LOSS_CYCLES,
  parameter int unsigned NV_WRITE_LIMIT  = `NV_WRITE_LIMIT
) (
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  // fault sources
  input  wire fault_in_t   FAULT_IN,
  input  wire logic        CTRL_PWR_OK_IN,
  input  wire logic        NV_WRITE_IN,
  // clearing actions
  input  wire logic        ALARM_CLEAR_IN,
  input  wire logic        PANEL_KEY_IN,
  // status
  output logic             TROUBLE_OUTPUT_OUT,
  output logic [15:0]      DISPLAY_CODE_OUT,
  output logic             ALARM_ACTIVE_OUT,
  output logic             WARN_ACTIVE_OUT
);

  // ****************************************
  // code lookup
  // ****************************************
  localparam logic [15:0] CLR_MASK = `ALM_CLEARABLE;

  // lowest set alarm position wins the display
  function automatic logic [15:0] alarm_code(input logic [15:0] v);
    logic [15:0] c;
    c = `CODE_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        unique case (i)
          `ALM_UNDERVOLT: c = `CODE_UNDERVOLT;
          `ALM_RAM:       c = `CODE_RAM;
          `ALM_NVMEM:     c = `CODE_NVMEM;
          `ALM_BOARD:     c = `CODE_BOARD;
          `ALM_FLASH:     c = `CODE_FLASH;
          `ALM_REGEN:     c = `CODE_REGEN;
          `ALM_OVERVOLT:  c = `CODE_OVERVOLT;
          `ALM_PARAM:     c = `CODE_PARAM;
          `ALM_MCDRIVE:   c = `CODE_MCDRIVE;
          `ALM_OPENPH:    c = `CODE_OPENPH;
          `ALM_INRUSH:    c = `CODE_INRUSH;
          `ALM_OVERHEAT:  c = `CODE_OVERHEAT;
          `ALM_FAN:       c = `CODE_FAN;
          `ALM_OVLD1:     c = `CODE_OVLD1;
          `ALM_OVLD2:     c = `CODE_OVLD2;
          default:        c = `CODE_WDOG;
        endcase
      end
    end
    return c;
  endfunction

  // lowest set warning wins
  function automatic logic [15:0] warn_code(input logic [4:0] w);
    logic [15:0] c;
    c = `CODE_NONE;
    if (w[4]) c = `CODE_W_FAN;
    if (w[3]) c = `CODE_W_STOP;
    if (w[2]) c = `CODE_W_OVLD;
    if (w[1]) c = `CODE_W_REGEN;
    if (w[0]) c = `CODE_W_HEAT;
    return c;
  endfunction

  // ****************************************
  // supply loss timer
  // ****************************************
  logic [31:0] loss_cnt_q;
  logic        loss_alarm;

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN || CTRL_PWR_OK_IN) begin
      loss_cnt_q <= 32'h0;
    end else if (loss_cnt_q < PWR_LOSS_CYCLES) begin
      loss_cnt_q <= loss_cnt_q + 32'h1;
    end
  end
  assign loss_alarm = (loss_cnt_q >= PWR_LOSS_CYCLES);

  // ****************************************
  // nonvolatile write counter
  // ****************************************
  logic [31:0] nv_cnt_q;
  logic        nv_alarm;

  // count writes, saturate past the limit
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      nv_cnt_q <= 32'h0;
    end else if (NV_WRITE_IN && nv_cnt_q <= NV_WRITE_LIMIT) begin
      nv_cnt_q <= nv_cnt_q + 32'h1;
    end
  end
  assign nv_alarm = (nv_cnt_q > NV_WRITE_LIMIT);

  // ****************************************
  // alarm latch
  // ****************************************
  logic [15:0] raw_alarms;
  logic [15:0] alarms_q;
  logic [15:0] alarms_d;
  logic        clear_req;

  always_comb begin
    raw_alarms = FAULT_IN.alarms;
    raw_alarms[`ALM_UNDERVOLT] = FAULT_IN.alarms[`ALM_UNDERVOLT] | loss_alarm;
    raw_alarms[`ALM_NVMEM]     = FAULT_IN.alarms[`ALM_NVMEM] | nv_alarm;
  end

  assign clear_req = ALARM_CLEAR_IN | PANEL_KEY_IN;

  // clear input drops only the clearable subset; new faults win
  always_comb begin
    alarms_d = alarms_q;
    if (clear_req) begin
      alarms_d = alarms_q & ~CLR_MASK;
    end
    alarms_d = alarms_d | raw_alarms;
  end

  // power-on reset clears all; otherwise held; board bit kept
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      alarms_q <= 16'h0000;
    end else begin
      alarms_q <= alarms_d;
    end
  end

  // ****************************************
  // state and outputs
  // ****************************************
  mgr_state_t state_q;

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      state_q <= ST_RUN;
    end else if (|alarms_d) begin
      state_q <= ST_ALARM;
    end else if (|FAULT_IN.warns) begin
      state_q <= ST_WARN;
    end else begin
      state_q <= ST_RUN;
    end
  end

  // trouble output high while healthy, low in alarm
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      TROUBLE_OUTPUT_OUT <= 1'b1;
      ALARM_ACTIVE_OUT   <= 1'b0;
      WARN_ACTIVE_OUT    <= 1'b0;
    end else begin
      TROUBLE_OUTPUT_OUT <= ~(|alarms_d);
      ALARM_ACTIVE_OUT   <= |alarms_d;
      WARN_ACTIVE_OUT    <= |FAULT_IN.warns;
    end
  end

  // alarm code first, then warning code
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      DISPLAY_CODE_OUT <= `CODE_NONE;
    end else if (|alarms_d) begin
      DISPLAY_CODE_OUT <= alarm_code(alarms_d);
    end else begin
      DISPLAY_CODE_OUT <= warn_code(FAULT_IN.warns);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_fault_in;
    |FAULT_IN.alarms;
  endsequence

  a_trouble_on_fault: assert property (s_fault_in |=> !TROUBLE_OUTPUT_OUT)
    else $error("trouble output not off after fault");
  // alarm codes keep their middle digit below 9, warning codes use 9 or e there
  a_display_alarm: assert property (ALARM_ACTIVE_OUT |-> DISPLAY_CODE_OUT[7:4] < 4'h9)
    else $error("warning code shown while alarm active");
  a_fault_shown: assert property (s_fault_in |=> DISPLAY_CODE_OUT != `CODE_NONE)
    else $error("fault not displayed");
  a_board_sticky: assert property (alarms_q[`ALM_BOARD] |=> alarms_q[`ALM_BOARD])
    else $error("board alarm cleared without power cycle");
  a_latch_hold: assert property (ALARM_ACTIVE_OUT && !clear_req |=> ALARM_ACTIVE_OUT)
    else $error("alarm dropped without clear");
  a_clear_subset: assert property (clear_req && !(|raw_alarms) |=> (alarms_q & CLR_MASK) == 16'h0)
    else $error("clearable alarm survived clear");
  a_loss_alarm: assert property (loss_alarm |=> alarms_q[`ALM_UNDERVOLT])
    else $error("supply loss not latched");
  a_nv_alarm: assert property (nv_alarm |=> alarms_q[`ALM_NVMEM])
    else $error("write limit not latched");
  a_warn_code: assert property (!(|alarms_d) && FAULT_IN.warns[0] |=> DISPLAY_CODE_OUT == `CODE_W_HEAT)
    else $error("overheat warning code wrong");
  a_reset_clear: assert property ($rose(RESET_N_IN) |-> !ALARM_ACTIVE_OUT)
    else $error("alarm survived reset");
  // a fault present during a clear request stays latched
  a_set_wins: assert property (clear_req |=> (alarms_q & $past(raw_alarms)) == $past(raw_alarms))
    else $error("fault lost under clear request");
  // state register tracks the trouble output
  a_state_track: assert property ((state_q == ST_ALARM) == !TROUBLE_OUTPUT_OUT)
    else $error("state and trouble output disagree");

endmodule
`default_nettype wire

/* test/host_ctrl_model.sv */
// host controller model: presses the clear input or the panel key on request
`default_nettype none
module host_ctrl_model (
  // clock and request from the bench
  input  wire logic clk_in,
  input  wire logic req_in,
  input  wire logic use_key_in,
  // towards the alarm manager
  input  wire logic trouble_in,
  output logic      clear_out = 1'b0,
  output logic      key_out   = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // clear on request
  // presses only while the trouble output shows an alarm, lets go once healthy
  always @(posedge clk_in) begin
    clear_out <= req_in & ~use_key_in & ~trouble_in;
    key_out   <= req_in & use_key_in & ~trouble_in;
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// testbench for the converter alarm manager
`include "alarm_mgr_defs.svh"
`default_nettype none
module tb_top
  import alarm_mgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pwr_ok = 1'b1;
  logic        nv_wr = 1'b0;
  logic        clr_req = 1'b0;
  logic        use_key = 1'b0;
  fault_in_t   flt = '0;
  wire logic   clr, key, trouble, trouble_output, wrn;
  wire logic [15:0] code;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [15:0] clr_mask = `ALM_CLEARABLE;
  logic [15:0] codes [16] = '{`CODE_UNDERVOLT, `CODE_RAM, `CODE_NVMEM, `CODE_BOARD, `CODE_FLASH,
    `CODE_REGEN, `CODE_OVERVOLT, `CODE_PARAM, `CODE_MCDRIVE, `CODE_OPENPH, `CODE_INRUSH,
    `CODE_OVERHEAT, `CODE_FAN, `CODE_OVLD1, `CODE_OVLD2, `CODE_WDOG};
  logic [15:0] wcodes [5] = '{`CODE_W_HEAT, `CODE_W_REGEN, `CODE_W_OVLD, `CODE_W_STOP, `CODE_W_FAN};
  // 25 MHz clock
  always #20 clk = ~clk;
  // device under test with short counts
  alarm_mgr #(.PWR_LOSS_CYCLES(20), .NV_WRITE_LIMIT(5)) i_alarm_mgr (
    .MCLK_IN(clk), .RESET_N_IN(rst_n), .FAULT_IN(flt), .CTRL_PWR_OK_IN(pwr_ok), .NV_WRITE_IN(nv_wr),
    .ALARM_CLEAR_IN(clr), .PANEL_KEY_IN(key), .TROUBLE_OUTPUT_OUT(trouble), .DISPLAY_CODE_OUT(code),
    .ALARM_ACTIVE_OUT(trouble_output), .WARN_ACTIVE_OUT(wrn));
  // host on the far side
  host_ctrl_model i_host_ctrl_model (
    .clk_in(clk), .req_in(clr_req), .use_key_in(use_key), .trouble_in(trouble),
    .clear_out(clr), .key_out(key));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task status(input logic a, input logic [15:0] c);
    chk("trouble", {15'h0000, ~a}, {15'h0000, trouble});
    chk("alarm_active", {15'h0000, a}, {15'h0000, trouble_output});
    chk("code", c, code);
  endtask
  task do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
  endtask
  task host_clear(input logic k);
    @(posedge clk);
    clr_req <= 1'b1;
    use_key <= k;
    repeat (4) @(posedge clk);
    clr_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // each alarm alone: latch, hold, clear or power cycle
  task alarm_each;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      flt.alarms <= 16'h0001 << i;
      @(posedge clk);
      flt.alarms <= 16'h0000;
      #1;
      status(1'b1, codes[i]);
      repeat (3) @(posedge clk);
      #1;
      status(1'b1, codes[i]);
      host_clear(i[0]);
      if (clr_mask[i]) begin
        status(1'b0, 16'h0000);
      end else begin
        status(1'b1, codes[i]);
        do_reset;
        status(1'b0, 16'h0000);
      end
    end
  endtask
  // each warning shows its own code without an alarm
  task warn_each;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      flt.warns <= 5'h01 << i;
      @(posedge clk);
      #1;
      status(1'b0, wcodes[i]);
      chk("warn_active", 16'h0001, {15'h0000, wrn});
      @(posedge clk);
      flt.warns <= 5'h00;
    end
    @(posedge clk);
    #1;
    chk("warn_active", 16'h0000, {15'h0000, wrn});
  endtask
  // several sources at once: lowest bit wins, a fault held through a clear stays latched
  task overlap;
    @(posedge clk);
    flt.warns <= 5'h1c;
    @(posedge clk);
    #1;
    status(1'b0, `CODE_W_OVLD);
    @(posedge clk);
    flt.alarms <= 16'h6000;
    @(posedge clk);
    #1;
    status(1'b1, `CODE_OVLD1);
    chk("warn_active", 16'h0001, {15'h0000, wrn});
    @(posedge clk);
    flt.alarms <= 16'h4000;
    host_clear(1'b0);
    status(1'b1, `CODE_OVLD2);
    @(posedge clk);
    flt.alarms <= 16'h0000;
    flt.warns <= 5'h00;
    host_clear(1'b1);
    status(1'b0, 16'h0000);
  endtask
  // control supply lost past the limit
  task supply_loss;
    @(posedge clk);
    pwr_ok <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    status(1'b0, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    status(1'b1, `CODE_UNDERVOLT);
    @(posedge clk);
    pwr_ok <= 1'b1;
    host_clear(1'b1);
    status(1'b0, 16'h0000);
  endtask
  // write endurance: alarm only on the write past the limit
  task nv_wear;
    for (int n = 1; n <= 6; n++) begin
      @(posedge clk);
      nv_wr <= 1'b1;
      @(posedge clk);
      nv_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      status(n > 5, (n > 5) ? `CODE_NVMEM : 16'h0000);
    end
    do_reset;
    status(1'b0, 16'h0000);
  endtask
  // main sequence
  initial begin
    do_reset;
    status(1'b0, 16'h0000);
    alarm_each;
    warn_each;
    overlap;
    supply_loss;
    nv_wear;
    print_verdict;
  end
  // hang guard
  initial begin
    #200us;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
